/* File: pkg/adcsp_consts.svh */
`ifndef ADCSP_CONSTS_SVH
`define ADCSP_CONSTS_SVH

// serial word geometry
`define ADCSP_BYTE_BITS 5'h08
`define ADCSP_WORD_BITS 5'h10

// communications register fields
`define ADCSP_COMM_RD_BIT 3
`define ADCSP_COMM_SEL_HI 5
`define ADCSP_COMM_SEL_LO 4

// setup register calibration-mode field
`define ADCSP_SETUP_CAL_HI 7
`define ADCSP_SETUP_CAL_LO 6
`define ADCSP_CAL_NONE 2'h0

// register-select codes
`define ADCSP_SEL_COMM 2'h0
`define ADCSP_SEL_SETUP 2'h1
`define ADCSP_SEL_CLOCK 2'h2
`define ADCSP_SEL_DATA 2'h3

// power-on values
`define ADCSP_COMM_RST 8'h00
`define ADCSP_SETUP_RST 8'h01
`define ADCSP_CLOCK_RST 8'h05
`define ADCSP_DATA_RST 16'h0000

// blanking before an update, in master clock periods
`define ADCSP_BLANK_TCLK 500
// one master clock period per mclk cycle
`define ADCSP_BLANK_CYCLES (`ADCSP_BLANK_TCLK * 1)

// defaults of the long counts, in mclk cycles
`define ADCSP_UPDATE_DEFAULT 20000
`define ADCSP_CAL_DEFAULT 6000

`endif

/* File: pkg/adcsp_pkg.sv */
package adcsp_pkg;

   typedef struct packed {
      logic [7:0] commReg;
      logic [7:0] setupReg;
      logic [7:0] clockReg;
   } adcsp_regs_t;

   typedef enum logic [1:0] {
      PH_COMM,
      PH_WRITE,
      PH_READ
   } adcsp_phase_t;

   typedef enum logic [1:0] {
      ST_WAIT,
      ST_READY,
      ST_BLANK,
      ST_CAL
   } adcsp_state_t;

endpackage

/* File: src/adcsp_serial_link.sv */
`timescale 1ns/1ns
`include "adcsp_consts.svh"

module adcsp_serial_link
(
   input wire logic sclk,
   input wire logic rst,
   input wire logic clearReq,
   input wire logic csN,
   input wire logic din,
   input wire logic [15:0] dataWord,
   output logic dout,
   output adcsp_pkg::adcsp_regs_t regs,
   output logic writeTgl,
   output logic readTgl
);

   logic clr1_q;
   logic clr2_q;
   adcsp_pkg::adcsp_phase_t phase_q;
   adcsp_pkg::adcsp_phase_t phase_d;
   logic [4:0] bitCnt_q;
   logic [4:0] bitCnt_d;
   logic [4:0] len_q;
   logic [4:0] len_d;
   logic [15:0] shiftIn_q;
   logic [15:0] shiftIn_d;
   logic [15:0] shiftOut_q;
   logic [15:0] shiftOut_d;
   adcsp_pkg::adcsp_regs_t regs_q;
   adcsp_pkg::adcsp_regs_t regs_d;
   logic wTgl_q;
   logic wTgl_d;
   logic rTgl_q;
   logic rTgl_d;

   function automatic logic [1:0] selOf(input logic [7:0] comm);
      selOf = comm[`ADCSP_COMM_SEL_HI:`ADCSP_COMM_SEL_LO];
   endfunction

   always_comb
   begin
      logic [7:0] newComm;
      logic [1:0] sel;
      newComm = {shiftIn_q[6:0], din};
      sel = selOf(regs_q.commReg);
      phase_d = phase_q;
      bitCnt_d = bitCnt_q;
      len_d = len_q;
      shiftIn_d = shiftIn_q;
      shiftOut_d = shiftOut_q;
      regs_d = regs_q;
      wTgl_d = wTgl_q;
      rTgl_d = rTgl_q;
      if (clr2_q)
      begin
         phase_d = adcsp_pkg::PH_COMM;
         bitCnt_d = 5'h00;
         regs_d.commReg = `ADCSP_COMM_RST;
         regs_d.setupReg = `ADCSP_SETUP_RST;
         regs_d.clockReg = `ADCSP_CLOCK_RST;
      end
      else if (csN)
         // deselect abandons a partial word; the phase is kept
         bitCnt_d = 5'h00;
      else
      begin
         shiftIn_d = {shiftIn_q[14:0], din};
         bitCnt_d = bitCnt_q + 5'h01;
         case (phase_q)
            adcsp_pkg::PH_COMM:
               if (bitCnt_q == `ADCSP_BYTE_BITS - 5'h01)
               begin
                  bitCnt_d = 5'h00;
                  regs_d.commReg = newComm;
                  len_d = (selOf(newComm) == `ADCSP_SEL_DATA) ?
                     `ADCSP_WORD_BITS : `ADCSP_BYTE_BITS;
                  if (newComm[`ADCSP_COMM_RD_BIT])
                  begin
                     phase_d = adcsp_pkg::PH_READ;
                     case (selOf(newComm))
                        `ADCSP_SEL_COMM: shiftOut_d = {newComm, 8'h00};
                        `ADCSP_SEL_SETUP:
                           shiftOut_d = {regs_q.setupReg, 8'h00};
                        `ADCSP_SEL_CLOCK:
                           shiftOut_d = {regs_q.clockReg, 8'h00};
                        default: shiftOut_d = dataWord;
                     endcase
                  end
                  else if (selOf(newComm) == `ADCSP_SEL_SETUP ||
                           selOf(newComm) == `ADCSP_SEL_CLOCK)
                     phase_d = adcsp_pkg::PH_WRITE;
               end
            adcsp_pkg::PH_WRITE:
               if (bitCnt_q == len_q - 5'h01)
               begin
                  bitCnt_d = 5'h00;
                  phase_d = adcsp_pkg::PH_COMM;
                  wTgl_d = ~wTgl_q;
                  if (sel == `ADCSP_SEL_SETUP)
                     regs_d.setupReg = newComm;
                  else
                     regs_d.clockReg = newComm;
               end
            adcsp_pkg::PH_READ:
            begin
               shiftOut_d = {shiftOut_q[14:0], 1'b0};
               if (bitCnt_q == len_q - 5'h01)
               begin
                  bitCnt_d = 5'h00;
                  phase_d = adcsp_pkg::PH_COMM;
                  if (sel == `ADCSP_SEL_DATA)
                     rTgl_d = ~rTgl_q;
               end
            end
            default:
               phase_d = adcsp_pkg::PH_COMM;
         endcase
      end
   end

   always_ff @(posedge sclk or posedge rst)
   begin
      if (rst)
      begin
         clr1_q <= 1'b1;
         clr2_q <= 1'b1;
         phase_q <= adcsp_pkg::PH_COMM;
         bitCnt_q <= 5'h00;
         len_q <= `ADCSP_BYTE_BITS;
         shiftIn_q <= 16'h0000;
         shiftOut_q <= 16'h0000;
         regs_q <= {`ADCSP_COMM_RST, `ADCSP_SETUP_RST, `ADCSP_CLOCK_RST};
         wTgl_q <= 1'b0;
         rTgl_q <= 1'b0;
      end
      else
      begin
         clr1_q <= clearReq;
         clr2_q <= clr1_q;
         phase_q <= phase_d;
         bitCnt_q <= bitCnt_d;
         len_q <= len_d;
         shiftIn_q <= shiftIn_d;
         shiftOut_q <= shiftOut_d;
         regs_q <= regs_d;
         wTgl_q <= wTgl_d;
         rTgl_q <= rTgl_d;
      end
   end

   assign dout = shiftOut_q[15];
   assign regs = regs_q;
   assign writeTgl = wTgl_q;
   assign readTgl = rTgl_q;

endmodule

/* File: src/adcsp_top.sv */
`timescale 1ns/1ns
`include "adcsp_consts.svh"

module adcsp_top
#(
   parameter int UPDATE_CYCLES = `ADCSP_UPDATE_DEFAULT,
   parameter int CAL_CYCLES = `ADCSP_CAL_DEFAULT
)
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic resetPinN,
   input wire logic sclk,
   input wire logic csN,
   input wire logic din,
   output logic dout,
   output logic doutOe,
   input wire logic [15:0] convWord,
   output logic resultReadyN,
   output logic [15:0] resultWord,
   output adcsp_pkg::adcsp_regs_t cfg,
   output logic calBusy
);

   localparam int CW = $clog2(UPDATE_CYCLES + CAL_CYCLES + 1);
   // ready rises on the edge after cnt hits BLANK_AT and falls on the edge
   // after UPD_LAST, so one extra count makes the window the full length
   localparam logic [CW-1:0] BLANK_AT =
      CW'(UPDATE_CYCLES - `ADCSP_BLANK_CYCLES - 1);
   localparam logic [CW-1:0] UPD_LAST = CW'(UPDATE_CYCLES - 1);
   localparam logic [CW-1:0] CAL_LAST = CW'(CAL_CYCLES - 1);

   logic rp1_q;
   logic rp2_q;
   logic rt1_q;
   logic rt2_q;
   logic rt3_q;
   logic wt1_q;
   logic wt2_q;
   logic wt3_q;
   logic readTgl;
   logic writeTgl;
   logic readDone;
   logic writeSeen;
   logic pinReset;
   adcsp_pkg::adcsp_regs_t linkRegs;

   adcsp_pkg::adcsp_state_t state_q;
   adcsp_pkg::adcsp_state_t state_d;
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic [CW-1:0] calCnt_q;
   logic [CW-1:0] calCnt_d;
   logic readyN_q;
   logic readyN_d;
   logic [15:0] data_q;
   logic [15:0] data_d;
   adcsp_pkg::adcsp_regs_t cfg_q;
   adcsp_pkg::adcsp_regs_t cfg_d;

   // the link reads data_q directly; it changes only at a pin reset or at an
   // update, the update inside the blanking window in which the controller must not be reading
   adcsp_serial_link link
   (
      .sclk(sclk),
      .rst(rst),
      .clearReq(pinReset),
      .csN(csN),
      .din(din),
      .dataWord(data_q),
      .dout(dout),
      .regs(linkRegs),
      .writeTgl(writeTgl),
      .readTgl(readTgl)
   );

   // dout is only driven while selected, so a shared bus stays free
   assign doutOe = ~csN;

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         rp1_q <= 1'b0;
         rp2_q <= 1'b0;
         rt1_q <= 1'b0;
         rt2_q <= 1'b0;
         rt3_q <= 1'b0;
         wt1_q <= 1'b0;
         wt2_q <= 1'b0;
         wt3_q <= 1'b0;
      end
      else
      begin
         rp1_q <= resetPinN;
         rp2_q <= rp1_q;
         rt1_q <= readTgl;
         rt2_q <= rt1_q;
         rt3_q <= rt2_q;
         wt1_q <= writeTgl;
         wt2_q <= wt1_q;
         wt3_q <= wt2_q;
      end
   end

   assign pinReset = ~rp2_q;
   assign readDone = rt2_q ^ rt3_q;
   assign writeSeen = wt2_q ^ wt3_q;

   always_comb
   begin
      state_d = state_q;
      cnt_d = cnt_q + CW'(1);
      calCnt_d = calCnt_q;
      data_d = data_q;
      cfg_d = cfg_q;
      // register values are quasi-static: the next write is at least a
      // byte of serial clocks away, longer than the toggle sync
      if (writeSeen)
         cfg_d = linkRegs;
      if (pinReset)
      begin
         state_d = adcsp_pkg::ST_WAIT;
         cnt_d = '0;
         calCnt_d = '0;
         data_d = `ADCSP_DATA_RST;
         cfg_d = {`ADCSP_COMM_RST, `ADCSP_SETUP_RST, `ADCSP_CLOCK_RST};
      end
      else if (writeSeen && linkRegs.setupReg[`ADCSP_SETUP_CAL_HI:
               `ADCSP_SETUP_CAL_LO] != `ADCSP_CAL_NONE)
      begin
         state_d = adcsp_pkg::ST_CAL;
         calCnt_d = '0;
      end
      else
      begin
         case (state_q)
            adcsp_pkg::ST_CAL:
            begin
               cnt_d = '0;
               calCnt_d = calCnt_q + CW'(1);
               if (calCnt_q == CAL_LAST)
                  state_d = adcsp_pkg::ST_READY;
            end
            adcsp_pkg::ST_READY:
               if (cnt_q == BLANK_AT)
                  state_d = adcsp_pkg::ST_BLANK;
               else if (readDone)
                  state_d = adcsp_pkg::ST_WAIT;
            adcsp_pkg::ST_WAIT:
               if (cnt_q == BLANK_AT)
                  state_d = adcsp_pkg::ST_BLANK;
            adcsp_pkg::ST_BLANK:
               if (cnt_q == UPD_LAST)
               begin
                  cnt_d = '0;
                  data_d = convWord;
                  state_d = adcsp_pkg::ST_READY;
               end
            default:
               state_d = adcsp_pkg::ST_WAIT;
         endcase
      end
      readyN_d = (state_d != adcsp_pkg::ST_READY);
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= adcsp_pkg::ST_WAIT;
         cnt_q <= '0;
         calCnt_q <= '0;
         readyN_q <= 1'b1;
         data_q <= `ADCSP_DATA_RST;
         cfg_q <= {`ADCSP_COMM_RST, `ADCSP_SETUP_RST, `ADCSP_CLOCK_RST};
      end
      else
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         calCnt_q <= calCnt_d;
         readyN_q <= readyN_d;
         data_q <= data_d;
         cfg_q <= cfg_d;
      end
   end

   assign resultReadyN = readyN_q;
   assign resultWord = data_q;
   assign cfg = cfg_q;
   assign calBusy = (state_q == adcsp_pkg::ST_CAL);

endmodule

/* File: tb/adcsp_top_sva.sv */
`timescale 1ns/1ns
module adcsp_top_sva
#(
   parameter int UPDATE_CYCLES = 20000,
   parameter int CAL_CYCLES = 6000
)
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic resetPinN,
   input wire logic sclk,
   input wire logic csN,
   input wire logic din,
   input wire logic dout,
   input wire logic doutOe,
   input wire logic [15:0] convWord,
   input wire logic resultReadyN,
   input wire logic [15:0] resultWord,
   input wire adcsp_pkg::adcsp_regs_t cfg,
   input wire logic calBusy
);
   int hiCnt_q;
   int calCnt_q;
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         hiCnt_q <= 0;
         calCnt_q <= 0;
      end
      else
      begin
         hiCnt_q <= resultReadyN ? hiCnt_q + 1 : 0;
         calCnt_q <= calBusy ? calCnt_q + 1 : 0;
      end
   end
   oe_follow_a: assert property (@(posedge mclk) disable iff (rst)
      doutOe == !csN) else $error("dout enable not tied to select");
   word_cap_a: assert property (@(posedge mclk) disable iff (rst)
      $fell(resultReadyN) && !$past(calBusy) |-> resultWord == $past(convWord))
      else $error("result word not captured at update");
   word_hold_a: assert property (@(posedge mclk) disable iff (rst)
      $changed(resultWord) && resultWord != 16'h0000 |-> $fell(resultReadyN))
      else $error("result word changed without ready");
   blank_len_a: assert property (@(posedge mclk) disable iff (rst)
      $fell(resultReadyN) && !$past(calBusy) |-> hiCnt_q >= 500)
      else $error("blank window shorter than 500 cycles");
   ready_max_a: assert property (@(posedge mclk) disable iff (rst)
      hiCnt_q <= UPDATE_CYCLES + CAL_CYCLES + 8)
      else $error("ready high for too long");
   cal_ready_a: assert property (@(posedge mclk) disable iff (rst)
      calBusy |-> resultReadyN) else $error("ready low during calibration");
   cal_len_a: assert property (@(posedge mclk) disable iff (rst)
      calCnt_q <= CAL_CYCLES + 2) else $error("calibration too long");
   cal_end_a: assert property (@(posedge mclk) disable iff (rst)
      $fell(calBusy) && resetPinN |-> !resultReadyN)
      else $error("no ready at calibration end");
   rst_vals_a: assert property (@(posedge mclk) rst |->
      cfg == 24'h000105 && resultReadyN && !calBusy && resultWord == 16'h0000)
      else $error("reset values wrong");
endmodule
bind adcsp_top adcsp_top_sva #(.UPDATE_CYCLES(UPDATE_CYCLES),
   .CAL_CYCLES(CAL_CYCLES)) chk_u (.mclk(mclk), .rst(rst),
   .resetPinN(resetPinN), .sclk(sclk), .csN(csN), .din(din), .dout(dout),
   .doutOe(doutOe), .convWord(convWord), .resultReadyN(resultReadyN),
   .resultWord(resultWord), .cfg(cfg), .calBusy(calBusy));

/* File: tb/adcsp_ctl_model.sv */
`timescale 1ns/1ns
module adcsp_ctl_model
(
   output logic sclk,
   output logic csN,
   output logic din,
   input wire logic dout
);
   initial
   begin
      sclk = 1'b0;
      csN = 1'b1;
      din = 1'b0;
   end
   // clock stands still between frames; released din flips
   task automatic xfer(input int n, input logic [23:0] w,
      output logic [23:0] r);
      r = 24'h000000;
      #7;
      csN = 1'b0;
      for (int i = n - 1; i >= 0; i--)
      begin
         din = w[i];
         #40;
         r = {r[22:0], dout};
         sclk = 1'b1;
         #40;
         sclk = 1'b0;
      end
      #40;
      csN = 1'b1;
      din = ~din;
   endtask
   task automatic idle(input int n);
      repeat (n)
      begin
         #40 sclk = 1'b1;
         #40 sclk = 1'b0;
      end
   endtask
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ns
module tb;
   logic mclk, rst, resetPinN, sclk, csN, din, dout, doutOe;
   logic resultReadyN, calBusy;
   logic [15:0] convWord, resultWord;
   adcsp_pkg::adcsp_regs_t cfg;
   logic [23:0] rd;
   int failCount, totalChecks, cyc;
   adcsp_top #(.UPDATE_CYCLES(1000), .CAL_CYCLES(50)) dut_u (.mclk(mclk),
      .rst(rst), .resetPinN(resetPinN), .sclk(sclk), .csN(csN), .din(din),
      .dout(dout), .doutOe(doutOe), .convWord(convWord),
      .resultReadyN(resultReadyN), .resultWord(resultWord), .cfg(cfg),
      .calBusy(calBusy));
   adcsp_ctl_model ctl_u (.sclk(sclk), .csN(csN), .din(din), .dout(dout));
   initial
   begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   task automatic check(input string what, input logic [23:0] seen, exp);
      totalChecks++;
      if (seen !== exp)
      begin
         failCount++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic testDone;
      $display("checks %0d mismatches %0d", totalChecks, failCount);
      if (failCount == 0 && totalChecks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 8000)
      begin
         failCount++;
         testDone();
      end
   end
   // data-register reads only start once ready is low
   task automatic waitReady(input logic lvl);
      int n;
      n = 0;
      while (resultReadyN !== lvl && n < 3000)
      begin
         @(negedge mclk);
         n++;
      end
      check("ready", resultReadyN, lvl);
   endtask
   task automatic regsTest;
      ctl_u.xfer(16, 24'h001002, rd);
      repeat (6) @(negedge mclk);
      check("setup", cfg.setupReg, 8'h02);
      ctl_u.xfer(16, 24'h001800, rd);
      check("setup rd", rd[7:0], 8'h02);
      ctl_u.xfer(16, 24'h0020a5, rd);
      ctl_u.xfer(16, 24'h002800, rd);
      check("clock rd", rd[7:0], 8'ha5);
      check("clock", cfg.clockReg, 8'ha5);
   endtask
   task automatic dataRead;
      waitReady(1'b0);
      check("word", resultWord, 16'h1234);
      ctl_u.xfer(8, 24'h000038, rd);
      // the word is read in two bursts; the clock stands still in between
      ctl_u.xfer(12, 24'h000000, rd);
      check("data hi", rd[11:0], 12'h123);
      repeat (10) @(negedge mclk);
      check("partial", resultReadyN, 1'b0);
      ctl_u.xfer(4, 24'h000000, rd);
      check("data lo", rd[3:0], 4'h4);
      repeat (10) @(negedge mclk);
      check("cleared", resultReadyN, 1'b1);
   endtask
   task automatic blankTest;
      int n;
      @(negedge mclk);
      convWord = 16'h5a3c;
      waitReady(1'b0);
      check("upd1", resultWord, 16'h5a3c);
      convWord = 16'hc3a5;
      waitReady(1'b1);
      n = 0;
      while (resultReadyN === 1'b1 && n < 2000)
      begin
         @(negedge mclk);
         n++;
      end
      check("blank", n, 500);
      check("upd2", resultWord, 16'hc3a5);
   endtask
   task automatic calTest;
      ctl_u.xfer(16, 24'h001042, rd);
      repeat (6) @(negedge mclk);
      check("cal busy", {calBusy, resultReadyN}, 2'h3);
      repeat (60) @(negedge mclk);
      check("cal done", {calBusy, resultReadyN}, 2'h0);
   endtask
   task automatic pinReset;
      resetPinN = 1'b0;
      repeat (5) @(negedge mclk);
      check("pin cfg", cfg, 24'h000105);
      check("pin out", {calBusy, resultReadyN, resultWord}, 18'h10000);
      resetPinN = 1'b1;
      repeat (4) @(negedge mclk);
      ctl_u.idle(4);
   endtask
   initial
   begin
      rst = 1'b1;
      resetPinN = 1'b1;
      convWord = 16'h1234;
      failCount = 0;
      totalChecks = 0;
      cyc = 0;
      ctl_u.idle(2);
      repeat (3) @(negedge mclk);
      rst = 1'b0;
      repeat (4) @(negedge mclk);
      ctl_u.idle(3);
      regsTest();
      dataRead();
      blankTest();
      calTest();
      pinReset();
      testDone();
   end
endmodule
